// file: rvr_i2c_host.sv
// I2C host model for the register bank's slave port.
// Assumes the bench resolves open-drain SDA with a pull-up.
`timescale 1ns/1ps
module rvr_i2c_host (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk_in);
	endtask : w
	// SCL phases of 4 clocks keep above the 2-clock minimum
	task automatic bit_x(input logic b, output logic r);
		sda_out <= b;
		w(2);
		scl_out <= 1'b1;
		w(4);
		r = sda_in;
		scl_out <= 1'b0;
		w(2);
	endtask : bit_x
	task automatic start();
		sda_out <= 1'b1;
		w(2);
		scl_out <= 1'b1;
		w(4);
		sda_out <= 1'b0;
		w(4);
		scl_out <= 1'b0;
		w(2);
	endtask : start
	task automatic stop();
		sda_out <= 1'b0;
		w(2);
		scl_out <= 1'b1;
		w(4);
		sda_out <= 1'b1;
		w(4);
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(ack_in, ack);
	endtask : xfer
endmodule : rvr_i2c_host

// file: rvr_pkg.sv
// Constants for the step-down rail voltage register bank.
// Assumes an 8-bit register space reached through the I2C slave port.
package rvr_pkg;
	localparam logic [7:0] RVR_OFS_RAIL_A = 8'h20;
	localparam logic [7:0] RVR_OFS_RAIL_B = 8'h21;
	localparam logic [7:0] RVR_OFS_RAIL_C_DECAY = 8'h22;
	localparam logic [7:0] RVR_OFS_RAIL_C_CODE = 8'h23;
	localparam int RVR_CODE_MSB = 7;
	localparam int RVR_CODE_LSB = 1;
	localparam int RVR_FALL_BIT = 0;
	localparam logic [7:0] RVR_UNMAPPED_READ = 8'h00;
	localparam logic [7:0] RVR_CODE_REG_MASK = 8'hFE;
	localparam logic [3:0] RVR_BITS_PER_BYTE = 4'h8;
	// Factory variant presets, indexed by variant number 0..3
	localparam logic [7:0] RVR_RAIL_A_PRESET [4] = '{8'hE8, 8'h70, 8'h02, 8'h78};
	localparam logic [7:0] RVR_RAIL_B_PRESET [4] = '{8'h64, 8'h5A, 8'h5A, 8'h70};
	localparam logic [7:0] RVR_RAIL_C_DECAY_PRESET [4] = '{8'h40, 8'h24, 8'h38, 8'h40};
	localparam logic [7:0] RVR_RAIL_C_CODE_PRESET [4] = '{8'h40, 8'h24, 8'h38, 8'h40};
	// Slave address; value is arbitrary
	localparam logic [6:0] RVR_I2C_ADDR = 7'h2E;
	typedef enum logic [3:0] {
		RVR_IDLE, RVR_ADDR, RVR_ACK_ADDR, RVR_PTR, RVR_ACK_PTR,
		RVR_WDATA, RVR_ACK_WR, RVR_READ, RVR_RACK
	} rvr_state_t;
endpackage : rvr_pkg

// file: rvr_reg_cell.sv
// One 8-bit read/write register with a preset value.
// Assumes a single-cycle write strobe in the clk_in domain.
`timescale 1ns/1ps
module rvr_reg_cell #(
	parameter logic [7:0] PRESET = 8'h00,
	parameter logic [7:0] WMASK = 8'hFF
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic we_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] q_out
);
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q_out <= PRESET & WMASK;
		end else if (we_in) begin
			q_out <= wdata_in & WMASK;
		end
	end
endmodule : rvr_reg_cell

// file: rvr_regs.sv
// Voltage code and fall-mode registers for three step-down rails behind an I2C slave.
// Assumes scl_in and sda_in are already synchronous to clk_in; SDA is open drain.
//
// What this block does
// - Rail A normal voltage code is read/write bits 7:1 of its control register.
// - Rail B normal voltage code is bits 7:1 of the register at 21h.
// - Rail C normal voltage code is bits 7:1 of the register at 23h.
// - Decay bit clear and lower code written: rail slews down actively.
// - Decay bit set and lower code written: output falls passively by load.
// - Rail C decay bit is bit 0 at 22h; bits 7:1 are spare storage.
// - Every register resets to a preset chosen by the factory variant.
`timescale 1ns/1ps
module rvr_regs #(
	parameter int VARIANT = 0
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic [6:0] rail_a_voltage_code_out,
	output logic rail_a_passive_fall_out,
	output logic rail_a_active_slew_out,
	output logic rail_a_passive_drop_out,
	output logic [6:0] rail_b_voltage_code_out,
	output logic rail_b_passive_fall_out,
	output logic rail_b_active_slew_out,
	output logic rail_b_passive_drop_out,
	output logic [6:0] rail_c_voltage_code_out,
	output logic rail_c_passive_fall_out,
	output logic rail_c_active_slew_out,
	output logic rail_c_passive_drop_out
);
	import rvr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Bus line conditions
	logic scl_reg;
	logic sda_reg;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end else begin
			scl_reg <= scl_in;
			sda_reg <= sda_in;
		end
	end
	wire start_cond = scl_in & scl_reg & sda_reg & ~sda_in;
	wire stop_cond = scl_in & scl_reg & ~sda_reg & sda_in;
	wire scl_rise = scl_in & ~scl_reg;
	wire scl_fall = ~scl_in & scl_reg;

	////////////////////////////////////////////////////////////////////////
	// Register file
	logic [7:0] rail_a_control;
	logic [7:0] rail_b_control;
	logic [7:0] rail_c_decay_control;
	logic [7:0] rail_c_voltage_code;
	logic wr_stb_reg;
	logic [7:0] wr_addr_reg;
	logic [7:0] wr_data_reg;
	logic [7:0] ptr_reg;

	wire we_a = wr_stb_reg & (wr_addr_reg == RVR_OFS_RAIL_A);
	wire we_b = wr_stb_reg & (wr_addr_reg == RVR_OFS_RAIL_B);
	wire we_cd = wr_stb_reg & (wr_addr_reg == RVR_OFS_RAIL_C_DECAY);
	wire we_cv = wr_stb_reg & (wr_addr_reg == RVR_OFS_RAIL_C_CODE);

	rvr_reg_cell #(.PRESET(RVR_RAIL_A_PRESET[VARIANT]), .WMASK(8'hFF)) u_rail_a (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .we_in(we_a), .wdata_in(wr_data_reg), .q_out(rail_a_control));
	rvr_reg_cell #(.PRESET(RVR_RAIL_B_PRESET[VARIANT]), .WMASK(8'hFF)) u_rail_b (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .we_in(we_b), .wdata_in(wr_data_reg), .q_out(rail_b_control));
	rvr_reg_cell #(.PRESET(RVR_RAIL_C_DECAY_PRESET[VARIANT]), .WMASK(8'hFF)) u_rail_c_decay (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .we_in(we_cd), .wdata_in(wr_data_reg),
		.q_out(rail_c_decay_control));
	// Bit 0 of the code register is reserved and reads zero
	rvr_reg_cell #(.PRESET(RVR_RAIL_C_CODE_PRESET[VARIANT]), .WMASK(RVR_CODE_REG_MASK)) u_rail_c_code (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .we_in(we_cv), .wdata_in(wr_data_reg),
		.q_out(rail_c_voltage_code));

	wire [6:0] new_code = wr_data_reg[RVR_CODE_MSB:RVR_CODE_LSB];
	wire lower_a = we_a & (new_code < rail_a_control[RVR_CODE_MSB:RVR_CODE_LSB]);
	wire lower_b = we_b & (new_code < rail_b_control[RVR_CODE_MSB:RVR_CODE_LSB]);
	wire lower_c = we_cv & (new_code < rail_c_voltage_code[RVR_CODE_MSB:RVR_CODE_LSB]);
	// Fall mode is the one in force when the lower code lands
	wire fall_a = we_a ? wr_data_reg[RVR_FALL_BIT] : rail_a_control[RVR_FALL_BIT];
	wire fall_b = we_b ? wr_data_reg[RVR_FALL_BIT] : rail_b_control[RVR_FALL_BIT];
	wire fall_c = rail_c_decay_control[RVR_FALL_BIT];

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rail_a_active_slew_out <= 1'b0;
			rail_a_passive_drop_out <= 1'b0;
			rail_b_active_slew_out <= 1'b0;
			rail_b_passive_drop_out <= 1'b0;
			rail_c_active_slew_out <= 1'b0;
			rail_c_passive_drop_out <= 1'b0;
		end else begin
			rail_a_active_slew_out <= lower_a & ~fall_a;
			rail_a_passive_drop_out <= lower_a & fall_a;
			rail_b_active_slew_out <= lower_b & ~fall_b;
			rail_b_passive_drop_out <= lower_b & fall_b;
			rail_c_active_slew_out <= lower_c & ~fall_c;
			rail_c_passive_drop_out <= lower_c & fall_c;
		end
	end

	// Codes pass untouched to the regulators
	assign rail_a_voltage_code_out = rail_a_control[RVR_CODE_MSB:RVR_CODE_LSB];
	assign rail_b_voltage_code_out = rail_b_control[RVR_CODE_MSB:RVR_CODE_LSB];
	assign rail_c_voltage_code_out = rail_c_voltage_code[RVR_CODE_MSB:RVR_CODE_LSB];
	assign rail_a_passive_fall_out = rail_a_control[RVR_FALL_BIT];
	assign rail_b_passive_fall_out = rail_b_control[RVR_FALL_BIT];
	assign rail_c_passive_fall_out = rail_c_decay_control[RVR_FALL_BIT];

	wire [7:0] rd_data =
		(ptr_reg == RVR_OFS_RAIL_A) ? rail_a_control :
		(ptr_reg == RVR_OFS_RAIL_B) ? rail_b_control :
		(ptr_reg == RVR_OFS_RAIL_C_DECAY) ? rail_c_decay_control :
		(ptr_reg == RVR_OFS_RAIL_C_CODE) ? rail_c_voltage_code : RVR_UNMAPPED_READ;

	////////////////////////////////////////////////////////////////////////
	// I2C slave
	rvr_state_t state_reg;
	logic [3:0] cnt_reg;
	logic [7:0] shift_reg;
	logic rw_reg;
	wire byte_done = (cnt_reg == RVR_BITS_PER_BYTE);
	wire [7:0] rx_byte = shift_reg;

	assign sda_out = 1'b0;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= RVR_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			rw_reg <= 1'b0;
			ptr_reg <= 8'h00;
			sda_oe_out <= 1'b0;
			wr_stb_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
		end else begin
			wr_stb_reg <= 1'b0;
			if (start_cond) begin
				state_reg <= RVR_ADDR;
				cnt_reg <= 4'h0;
				sda_oe_out <= 1'b0;
			end else if (stop_cond) begin
				state_reg <= RVR_IDLE;
				sda_oe_out <= 1'b0;
			end else begin
				case (state_reg)
				RVR_ADDR, RVR_PTR, RVR_WDATA: begin
					if (scl_rise && !byte_done) begin
						shift_reg <= {shift_reg[6:0], sda_in};
						cnt_reg <= cnt_reg + 4'h1;
					end else if (scl_fall && byte_done) begin
						cnt_reg <= 4'h0;
						sda_oe_out <= 1'b1;
						if (state_reg == RVR_ADDR) begin
							if (rx_byte[7:1] == RVR_I2C_ADDR) begin
								rw_reg <= rx_byte[0];
								state_reg <= RVR_ACK_ADDR;
							end else begin
								sda_oe_out <= 1'b0;
								state_reg <= RVR_IDLE;
							end
						end else if (state_reg == RVR_PTR) begin
							ptr_reg <= rx_byte;
							state_reg <= RVR_ACK_PTR;
						end else begin
							wr_stb_reg <= 1'b1;
							wr_addr_reg <= ptr_reg;
							wr_data_reg <= rx_byte;
							state_reg <= RVR_ACK_WR;
						end
					end
				end
				RVR_ACK_ADDR: begin
					if (scl_fall) begin
						if (rw_reg) begin
							shift_reg <= rd_data;
							sda_oe_out <= ~rd_data[7];
							cnt_reg <= 4'h1;
							state_reg <= RVR_READ;
						end else begin
							sda_oe_out <= 1'b0;
							state_reg <= RVR_PTR;
						end
					end
				end
				RVR_ACK_PTR, RVR_ACK_WR: begin
					if (scl_fall) begin
						sda_oe_out <= 1'b0;
						if (state_reg == RVR_ACK_WR) begin
							ptr_reg <= ptr_reg + 8'h01;
						end
						state_reg <= RVR_WDATA;
					end
				end
				RVR_READ: begin
					if (scl_fall) begin
						if (byte_done) begin
							sda_oe_out <= 1'b0;
							ptr_reg <= ptr_reg + 8'h01;
							state_reg <= RVR_RACK;
						end else begin
							sda_oe_out <= ~shift_reg[3'h7 - cnt_reg[2:0]];
							cnt_reg <= cnt_reg + 4'h1;
						end
					end
				end
				RVR_RACK: begin
					if (scl_rise && sda_in) begin
						state_reg <= RVR_IDLE;
					end else if (scl_fall) begin
						shift_reg <= rd_data;
						sda_oe_out <= ~rd_data[7];
						cnt_reg <= 4'h1;
						state_reg <= RVR_READ;
					end
				end
				default: begin
					sda_oe_out <= 1'b0;
				end
				endcase
			end
		end
	end
endmodule : rvr_regs

// file: rvr_regs_properties.sv
// Concurrent checks on the rail voltage register bank outputs.
// Assumes binding to rvr_regs; sees only its ports.
`timescale 1ns/1ps
module rvr_regs_properties
	import rvr_pkg::*;
#(
	parameter int VARIANT = 0
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [6:0] rail_a_voltage_code_out,
	input wire logic [6:0] rail_b_voltage_code_out,
	input wire logic rail_b_passive_fall_out,
	input wire logic rail_b_active_slew_out,
	input wire logic rail_c_passive_fall_out,
	input wire logic rail_c_passive_drop_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	////////////////////////////////////////////////////////////////
	a_slew_single_cycle: assert property (rail_b_active_slew_out |=> !rail_b_active_slew_out)
		else $error("rail b slew pulse too long");
	a_slew_fall_clear: assert property (rail_b_active_slew_out |-> !rail_b_passive_fall_out)
		else $error("rail b slew with decay set");
	// Code register and pulse update on the same edge
	a_slew_lower_code: assert property (
		rail_b_active_slew_out |-> rail_b_voltage_code_out < $past(rail_b_voltage_code_out))
		else $error("rail b slew without lower code");
	a_lower_gives_slew: assert property (
		rail_b_voltage_code_out < $past(rail_b_voltage_code_out) && !rail_b_passive_fall_out
		|-> rail_b_active_slew_out)
		else $error("rail b lower code gave no slew");
	a_drop_fall_set: assert property (rail_c_passive_drop_out |-> rail_c_passive_fall_out)
		else $error("rail c drop with decay clear");
	a_drop_single_cycle: assert property (rail_c_passive_drop_out |=> !rail_c_passive_drop_out)
		else $error("rail c drop pulse too long");
	a_preset_rail_a: assert property (
		$rose(arst_n_in) |-> rail_a_voltage_code_out == RVR_RAIL_A_PRESET[VARIANT][7:1])
		else $error("rail a code not preset");
	a_preset_rail_b: assert property (
		$rose(arst_n_in) |-> rail_b_voltage_code_out == RVR_RAIL_B_PRESET[VARIANT][7:1])
		else $error("rail b code not preset");
	c_slew: cover property (rail_b_active_slew_out);
	c_drop: cover property (rail_c_passive_drop_out);
	c_release: cover property ($rose(arst_n_in));
endmodule : rvr_regs_properties

bind rvr_regs rvr_regs_properties #(.VARIANT(VARIANT)) rvr_regs_properties_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
	.rail_a_voltage_code_out(rail_a_voltage_code_out), .rail_b_voltage_code_out(rail_b_voltage_code_out),
	.rail_b_passive_fall_out(rail_b_passive_fall_out), .rail_b_active_slew_out(rail_b_active_slew_out),
	.rail_c_passive_fall_out(rail_c_passive_fall_out), .rail_c_passive_drop_out(rail_c_passive_drop_out));

// file: test_rvr_regs.sv
// Self-checking bench for the rail voltage register bank.
// Assumes variant 0 presets and the I2C host model as bus master.
`timescale 1ns/1ps
module test_rvr_regs;
	import rvr_pkg::*;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic scl, host_sda, sda_oe, sda_dat;
	logic [6:0] code_a, code_b, code_c;
	logic [2:0] fall, slew, drop;
	logic [2:0] slew_seen = 3'h0;
	logic [2:0] drop_seen = 3'h0;
	int err_total = 0;
	int comparisons = 0;
	wire sda_wire;
	// Open drain with pull-up: low if either side pulls it
	assign sda_wire = host_sda & ~(sda_oe & ~sda_dat);
	always #10 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		if (arst_n_in) begin
			slew_seen <= slew_seen | slew;
			drop_seen <= drop_seen | drop;
		end
	end
	rvr_i2c_host rvr_i2c_host_i (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl), .sda_out(host_sda));
	rvr_regs #(.VARIANT(0)) rvr_regs_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_dat), .sda_oe_out(sda_oe), .rail_a_voltage_code_out(code_a), .rail_a_passive_fall_out(fall[0]),
		.rail_a_active_slew_out(slew[0]), .rail_a_passive_drop_out(drop[0]), .rail_b_voltage_code_out(code_b),
		.rail_b_passive_fall_out(fall[1]), .rail_b_active_slew_out(slew[1]), .rail_b_passive_drop_out(drop[1]),
		.rail_c_voltage_code_out(code_c), .rail_c_passive_fall_out(fall[2]), .rail_c_active_slew_out(slew[2]),
		.rail_c_passive_drop_out(drop[2]));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		logic [7:0] q;
		logic a0, a1, a2;
		rvr_i2c_host_i.start();
		rvr_i2c_host_i.xfer({RVR_I2C_ADDR, 1'b0}, 1'b1, q, a0);
		rvr_i2c_host_i.xfer(ofs, 1'b1, q, a1);
		rvr_i2c_host_i.xfer(d, 1'b1, q, a2);
		rvr_i2c_host_i.stop();
		chk({5'h0, a0, a1, a2}, 8'h00);
	endtask : wr
	// Pointer write, repeated start, one byte read ended by NACK
	task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] q;
		logic a0, a1, a2, a3;
		rvr_i2c_host_i.start();
		rvr_i2c_host_i.xfer({RVR_I2C_ADDR, 1'b0}, 1'b1, q, a0);
		rvr_i2c_host_i.xfer(ofs, 1'b1, q, a1);
		rvr_i2c_host_i.start();
		rvr_i2c_host_i.xfer({RVR_I2C_ADDR, 1'b1}, 1'b1, q, a2);
		rvr_i2c_host_i.xfer(8'hFF, 1'b1, q, a3);
		rvr_i2c_host_i.stop();
		chk({5'h0, a0, a1, a2}, 8'h00);
		chk(q, exp);
	endtask : rd
	task automatic conclude();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_in);
		arst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		rd(RVR_OFS_RAIL_A, RVR_RAIL_A_PRESET[0]);
		rd(RVR_OFS_RAIL_B, RVR_RAIL_B_PRESET[0]);
		rd(RVR_OFS_RAIL_C_DECAY, RVR_RAIL_C_DECAY_PRESET[0]);
		rd(RVR_OFS_RAIL_C_CODE, RVR_RAIL_C_CODE_PRESET[0]);
		rd(8'h30, RVR_UNMAPPED_READ);
		chk({1'b0, code_c}, {1'b0, RVR_RAIL_C_CODE_PRESET[0][7:1]});
		wr(RVR_OFS_RAIL_B, 8'h50);
		chk({1'b0, code_b}, 8'h28);
		chk({2'b0, slew_seen, drop_seen}, 8'h10);
		// Higher code gives no new pulse
		wr(RVR_OFS_RAIL_B, 8'h60);
		chk({1'b0, code_b}, 8'h30);
		chk({2'b0, slew_seen, drop_seen}, 8'h10);
		wr(RVR_OFS_RAIL_A, 8'h31);
		chk({fall[0], code_a}, 8'h98);
		chk({2'b0, slew_seen, drop_seen}, 8'h11);
		wr(RVR_OFS_RAIL_C_DECAY, 8'h01);
		wr(RVR_OFS_RAIL_C_CODE, 8'h21);
		rd(RVR_OFS_RAIL_C_CODE, 8'h20);
		rd(RVR_OFS_RAIL_C_DECAY, 8'h01);
		chk({fall[2], code_c}, 8'h90);
		chk({2'b0, slew_seen, drop_seen}, 8'h15);
		chk({5'h0, fall}, 8'h05);
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		err_total++;
		conclude();
	end
endmodule : test_rvr_regs
